// File: clc_map.svh
// Command codes, field positions, reset values and read value of the loop configuration bank
`ifndef CLC_MAP_SVH
`define CLC_MAP_SVH

// Command codes of the three registers
`define CLC_ADDR_RAMP_FREQ      8'hD3
`define CLC_ADDR_OFFSET         8'hD4
`define CLC_ADDR_LOCKOUT        8'hD6

// Field positions in the ramp and frequency register
`define CLC_RAMP_INJ_BIT        7
`define CLC_RAMP_RES_HI         5
`define CLC_RAMP_RES_LO         4
`define CLC_FREQ_HI             2
`define CLC_FREQ_LO             0

// Field positions in the offset register
`define CLC_OFS_SCHEME_BIT      7
`define CLC_OFS_STEP_HI         6
`define CLC_OFS_STEP_LO         5

// Field positions in the lockout register
`define CLC_UVLO_HI             2
`define CLC_UVLO_LO             0

// Reset values
`define CLC_RST_RAMP_INJ        1'h0
`define CLC_RST_RAMP_RES        2'h0
`define CLC_RST_FREQ            3'h3
`define CLC_RST_OFS_SCHEME      1'h1
`define CLC_RST_OFS_STEP        2'h0
`define CLC_RST_UVLO            3'h5

// Read value of reserved bits and of unmapped codes
`define CLC_READ_ZERO           8'h00

`endif

// File: clc_pkg.sv
// Types shared by the loop configuration bank
package clc_pkg;

  // Levels sampled from the strap pins
  typedef struct packed {
    logic       ramp_injection_enable;
    logic [1:0] ramp_resistor_select;
  } clc_strap_t;

  // Static select codes handed to the analog loop
  typedef struct packed {
    logic       ramp_injection_enable;
    logic [1:0] ramp_resistor_select;
    logic [2:0] switching_freq_code;
    logic       offset_scheme_select;
    logic [1:0] offset_correction_step;
    logic [2:0] bias_lockout_threshold_code;
  } clc_analog_t;

  // Strap capture sequence after reset release
  typedef enum logic [1:0] {
    CLC_SETTLE_A = 2'b00,
    CLC_SETTLE_B = 2'b01,
    CLC_LOAD     = 2'b10,
    CLC_RUN      = 2'b11
  } clc_state_t;

endpackage : clc_pkg

// File: clc_field_reg.sv
// One writable configuration field with an optional strap load
`timescale 1ns/100ps
module clc_field_reg #(
  parameter int             WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             load_en,
  input  wire logic [WIDTH-1:0] load_data,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] next_q;

  // Strap load and host write never meet, the top keeps writes out until loading is over
  always_comb begin
    next_q = q;
    if (load_en) begin
      next_q = load_data;
    end else if (wr_en) begin
      next_q = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RESET;
    end else begin
      q <= next_q;
    end
  end

  a_field_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !load_en |=> q == $past(wr_data))
    else $error("field did not take written value");

  a_field_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_en && !load_en |=> $stable(q))
    else $error("field changed without write or load");

endmodule : clc_field_reg

// File: clc_loop_cfg.sv
// Loop configuration register bank: ramp, frequency, offset and bias lockout settings
//
// How it works
// - Ramp injection bit loads from strap, writable
// - Ramp resistor select loads from strap, writable
// - Frequency code writable, resets to three
// - Offset scheme bit writable, resets to automatic
// - Offset step applies only in manual scheme
// - Lockout threshold code writable, resets to five
`timescale 1ns/100ps
`include "clc_map.svh"
module clc_loop_cfg
  import clc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire clc_strap_t  strap_pin,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_en,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic             cmd_hit,
  output logic             strap_done,
  output clc_analog_t      analog_out
);

  clc_strap_t  strap_sync1;
  clc_strap_t  strap_sync2;
  clc_state_t  state;
  clc_state_t  next_state;
  logic        next_strap_done;
  logic        load_en;
  logic        wr_ok;
  logic        hit_ramp;
  logic        hit_ofs;
  logic        hit_uvlo;
  logic [7:0]  reg_ramp;
  logic [7:0]  reg_ofs;
  logic [7:0]  reg_uvlo;
  logic [7:0]  next_rd_data;
  logic        next_rd_valid;
  logic        next_cmd_hit;
  clc_analog_t next_analog;
  logic        f_ramp_inj;
  logic [1:0]  f_ramp_res;
  logic [2:0]  f_freq;
  logic        f_ofs_scheme;
  logic [1:0]  f_ofs_step;
  logic [2:0]  f_uvlo;

  // Strap pins come from outside the clock domain, two flops before anything reads them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_sync1 <= '0;
      strap_sync2 <= '0;
    end else begin
      strap_sync1 <= strap_pin;
      strap_sync2 <= strap_sync1;
    end
  end

  // Wait for the synchroniser to fill after release, then load the straps once
  always_comb begin
    next_state      = state;
    next_strap_done = strap_done;
    case (state)
      CLC_SETTLE_A: begin
        next_state = CLC_SETTLE_B;
      end
      CLC_SETTLE_B: begin
        next_state = CLC_LOAD;
      end
      CLC_LOAD: begin
        next_state      = CLC_RUN;
        next_strap_done = 1'b1;
      end
      CLC_RUN: begin
        next_state = CLC_RUN;
      end
      default: begin
        next_state = CLC_SETTLE_A;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= CLC_SETTLE_A;
      strap_done <= 1'b0;
    end else begin
      state      <= next_state;
      strap_done <= next_strap_done;
    end
  end

  assign load_en = (state == CLC_LOAD);
  // Writes before the straps land would be lost, so they are refused until then
  assign wr_ok   = wr_en && (state == CLC_RUN);

  // Command decode
  always_comb begin
    hit_ramp = 1'b0;
    hit_ofs  = 1'b0;
    hit_uvlo = 1'b0;
    if (cmd_code == `CLC_ADDR_RAMP_FREQ) begin
      hit_ramp = 1'b1;
    end else if (cmd_code == `CLC_ADDR_OFFSET) begin
      hit_ofs = 1'b1;
    end else if (cmd_code == `CLC_ADDR_LOCKOUT) begin
      hit_uvlo = 1'b1;
    end
  end

  // Ramp injection enable, strap loaded
  clc_field_reg #(.WIDTH(1), .RESET(`CLC_RST_RAMP_INJ)) u_ramp_inj (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (wr_ok && hit_ramp),
    .wr_data   (wr_data[`CLC_RAMP_INJ_BIT]),
    .load_en   (load_en),
    .load_data (strap_sync2.ramp_injection_enable),
    .q         (f_ramp_inj)
  );

  // Ramp resistor select, strap loaded
  clc_field_reg #(.WIDTH(2), .RESET(`CLC_RST_RAMP_RES)) u_ramp_res (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (wr_ok && hit_ramp),
    .wr_data   (wr_data[`CLC_RAMP_RES_HI:`CLC_RAMP_RES_LO]),
    .load_en   (load_en),
    .load_data (strap_sync2.ramp_resistor_select),
    .q         (f_ramp_res)
  );

  // Switching frequency code
  clc_field_reg #(.WIDTH(3), .RESET(`CLC_RST_FREQ)) u_freq (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (wr_ok && hit_ramp),
    .wr_data   (wr_data[`CLC_FREQ_HI:`CLC_FREQ_LO]),
    .load_en   (1'b0),
    .load_data (3'h0),
    .q         (f_freq)
  );

  // Offset scheme select
  clc_field_reg #(.WIDTH(1), .RESET(`CLC_RST_OFS_SCHEME)) u_ofs_scheme (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (wr_ok && hit_ofs),
    .wr_data   (wr_data[`CLC_OFS_SCHEME_BIT]),
    .load_en   (1'b0),
    .load_data (1'h0),
    .q         (f_ofs_scheme)
  );

  // Offset correction step
  clc_field_reg #(.WIDTH(2), .RESET(`CLC_RST_OFS_STEP)) u_ofs_step (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (wr_ok && hit_ofs),
    .wr_data   (wr_data[`CLC_OFS_STEP_HI:`CLC_OFS_STEP_LO]),
    .load_en   (1'b0),
    .load_data (2'h0),
    .q         (f_ofs_step)
  );

  // Bias lockout threshold code
  clc_field_reg #(.WIDTH(3), .RESET(`CLC_RST_UVLO)) u_uvlo (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (wr_ok && hit_uvlo),
    .wr_data   (wr_data[`CLC_UVLO_HI:`CLC_UVLO_LO]),
    .load_en   (1'b0),
    .load_data (3'h0),
    .q         (f_uvlo)
  );

  // Read images, reserved bits tied low and never stored
  always_comb begin
    reg_ramp = `CLC_READ_ZERO;
    reg_ofs  = `CLC_READ_ZERO;
    reg_uvlo = `CLC_READ_ZERO;
    reg_ramp[`CLC_RAMP_INJ_BIT]                 = f_ramp_inj;
    reg_ramp[`CLC_RAMP_RES_HI:`CLC_RAMP_RES_LO] = f_ramp_res;
    reg_ramp[`CLC_FREQ_HI:`CLC_FREQ_LO]         = f_freq;
    reg_ofs[`CLC_OFS_SCHEME_BIT]                = f_ofs_scheme;
    reg_ofs[`CLC_OFS_STEP_HI:`CLC_OFS_STEP_LO]  = f_ofs_step;
    reg_uvlo[`CLC_UVLO_HI:`CLC_UVLO_LO]         = f_uvlo;
  end

  // Read answer one cycle after the strobe; unmapped codes answer zero with no hit
  always_comb begin
    next_rd_data  = rd_data;
    next_rd_valid = rd_en;
    next_cmd_hit  = cmd_hit;
    if (rd_en) begin
      next_rd_data = `CLC_READ_ZERO;
      next_cmd_hit = hit_ramp || hit_ofs || hit_uvlo;
      if (hit_ramp) begin
        next_rd_data = reg_ramp;
      end else if (hit_ofs) begin
        next_rd_data = reg_ofs;
      end else if (hit_uvlo) begin
        next_rd_data = reg_uvlo;
      end
    end else if (wr_en) begin
      next_cmd_hit = hit_ramp || hit_ofs || hit_uvlo;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data  <= `CLC_READ_ZERO;
      rd_valid <= 1'b0;
      cmd_hit  <= 1'b0;
    end else begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
      cmd_hit  <= next_cmd_hit;
    end
  end

  // Select codes to the analog side; the step is forced to zero under the automatic scheme
  always_comb begin
    next_analog.ramp_injection_enable       = f_ramp_inj;
    next_analog.ramp_resistor_select        = f_ramp_res;
    next_analog.switching_freq_code         = f_freq;
    next_analog.offset_scheme_select        = f_ofs_scheme;
    next_analog.offset_correction_step      = f_ofs_scheme ? 2'h0 : f_ofs_step;
    next_analog.bias_lockout_threshold_code = f_uvlo;
  end

  // A register stage keeps glitches of the decode off the analog selects
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analog_out <= {`CLC_RST_RAMP_INJ, `CLC_RST_RAMP_RES, `CLC_RST_FREQ,
                     `CLC_RST_OFS_SCHEME, `CLC_RST_OFS_STEP, `CLC_RST_UVLO};
    end else begin
      analog_out <= next_analog;
    end
  end

  a_strap_loads: assert property (@(posedge clk) disable iff (!rst_n)
    state == CLC_LOAD |=> f_ramp_inj == $past(strap_sync2.ramp_injection_enable)
      && f_ramp_res == $past(strap_sync2.ramp_resistor_select) && strap_done)
    else $error("strap values not loaded");

  a_ramp_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && state == CLC_RUN && cmd_code == 8'hD3 |=> ##1
      analog_out.ramp_injection_enable == $past(wr_data[7], 2)
      && analog_out.ramp_resistor_select == $past(wr_data[5:4], 2))
    else $error("ramp write did not reach analog selects");

  a_freq_reset: assert property (@(posedge clk)
    !rst_n |=> f_freq == 3'h3 && f_uvlo == 3'h5 && f_ofs_scheme == 1'b1
      && f_ofs_step == 2'h0)
    else $error("reset values wrong");

  a_ofs_scheme_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && state == CLC_RUN && cmd_code == 8'hD4 |=> f_ofs_scheme == $past(wr_data[7]))
    else $error("offset scheme write lost");

  a_ofs_gated: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 analog_out.offset_correction_step == ($past(f_ofs_scheme) ? 2'h0 : $past(f_ofs_step)))
    else $error("offset step not gated by scheme");

  // Write, one idle edge with no other write, then the read; the host paces accesses this way
  a_uvlo_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && state == CLC_RUN && cmd_code == 8'hD6 ##1 !wr_en
      ##1 rd_en && cmd_code == 8'hD6
      |=> rd_valid && rd_data == {5'h00, $past(wr_data[2:0], 3)})
    else $error("lockout code readback wrong");

  // Reserved bits are checked against the code that was actually read
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rd_valid |-> ($past(cmd_code) != 8'hD3 || (rd_data & 8'h48) == 8'h00)
      && ($past(cmd_code) != 8'hD4 || (rd_data & 8'h1F) == 8'h00)
      && ($past(cmd_code) != 8'hD6 || (rd_data & 8'hF8) == 8'h00)
      && (cmd_hit || rd_data == 8'h00))
    else $error("reserved bits read nonzero");

  a_early_write_refused: assert property (@(posedge clk) disable iff (!rst_n)
    state != CLC_RUN && state != CLC_LOAD |=> $stable(f_freq) && $stable(f_uvlo))
    else $error("write taken before strap load");

endmodule : clc_loop_cfg

// File: clc_host_model.sv
// Host model that reaches the configuration bank through its command and strobe port
`timescale 1ns/100ps
module clc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  input  wire logic       cmd_hit,
  output logic      [7:0] cmd_code,
  output logic            wr_en,
  output logic      [7:0] wr_data,
  output logic            rd_en
);
  // Idle bus at time zero
  initial begin
    cmd_code = 8'h00;
    wr_en    = 1'b0;
    wr_data  = 8'h00;
    rd_en    = 1'b0;
  end

  // One write: strobe stands for exactly one rising edge
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge clk);
    #1;
    cmd_code = code;
    wr_data  = data;
    wr_en    = 1'b1;
    @(posedge clk);
    #1;
    wr_en    = 1'b0;
    wr_data  = ~data; // Released lines must not keep the last value
    cmd_code = ~code;
  endtask : wr

  // One read: answer is taken 1 ns after the edge that samples the strobe
  task automatic rd(input logic [7:0] code, output logic [7:0] data, output logic hit,
                    output logic valid);
    @(posedge clk);
    #1;
    cmd_code = code;
    rd_en    = 1'b1;
    @(posedge clk);
    #1;
    rd_en    = 1'b0;
    data     = rd_data;
    hit      = cmd_hit;
    valid    = rd_valid;
    cmd_code = ~code;
  endtask : rd
endmodule : clc_host_model

// File: tb_top.sv
// Self-checking testbench of the loop configuration bank
`timescale 1ns/100ps
`include "clc_map.svh"
module tb_top;
  import clc_pkg::*;
  logic        clk;
  logic        rst_n;
  clc_strap_t  strap_pin;
  logic [7:0]  cmd_code;
  logic        wr_en;
  logic [7:0]  wr_data;
  logic        rd_en;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        cmd_hit;
  logic        strap_done;
  clc_analog_t analog_out;
  int          err_count = 0;
  int          check_count = 0;

  clc_loop_cfg clc_loop_cfg_inst (.clk(clk), .rst_n(rst_n), .strap_pin(strap_pin),
    .cmd_code(cmd_code), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
    .rd_data(rd_data), .rd_valid(rd_valid), .cmd_hit(cmd_hit),
    .strap_done(strap_done), .analog_out(analog_out));

  clc_host_model clc_host_model_inst (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_hit(cmd_hit), .cmd_code(cmd_code), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run, also reached when a wait runs out
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Read and compare data, hit flag and valid pulse
  task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp, input logic exp_hit);
    logic [7:0] d;
    logic       h;
    logic       v;
    clc_host_model_inst.rd(code, d, h, v);
    check("rd_data", {4'h0, d}, {4'h0, exp});
    check("cmd_hit", {11'h000, h}, {11'h000, exp_hit});
    check("rd_valid", {11'h000, v}, 12'h001);
  endtask : rd_chk

  // Reset for three cycles, then wait a bounded time for the strap load
  task automatic do_reset(input clc_strap_t s);
    int n;
    rst_n     = 1'b0;
    strap_pin = s;
    repeat (3) @(posedge clk);
    #1;
    check("analog_rst", analog_out, {1'b0, 2'b00, 3'h3, 1'b1, 2'b00, 3'h5});
    check("strap_done_rst", {11'h000, strap_done}, 12'h000);
    rst_n = 1'b1;
    // Lands before the straps, so it must be dropped; the lockout reads back its reset code
    clc_host_model_inst.wr(`CLC_ADDR_LOCKOUT, 8'h02);
    n = 0;
    while (strap_done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (strap_done !== 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask : do_reset

  initial begin
    logic [3:0] i;
    rst_n     = 1'b0;
    strap_pin = 3'b111;
    do_reset(3'b111);
    // Strap and reset values
    rd_chk(`CLC_ADDR_RAMP_FREQ, 8'hB3, 1'b1);
    rd_chk(`CLC_ADDR_OFFSET, 8'h80, 1'b1);
    rd_chk(`CLC_ADDR_LOCKOUT, 8'h05, 1'b1);
    check("analog", analog_out, {1'b1, 2'b11, 3'h3, 1'b1, 2'b00, 3'h5});
    // Host overwrite, reserved bits stay zero
    clc_host_model_inst.wr(`CLC_ADDR_RAMP_FREQ, 8'hFF);
    rd_chk(`CLC_ADDR_RAMP_FREQ, 8'hB7, 1'b1);
    clc_host_model_inst.wr(`CLC_ADDR_RAMP_FREQ, 8'h00);
    rd_chk(`CLC_ADDR_RAMP_FREQ, 8'h00, 1'b1);
    // Every frequency code with nominal resistor
    for (i = 0; i < 8; i++) begin
      clc_host_model_inst.wr(`CLC_ADDR_RAMP_FREQ, {5'h02, i[2:0]});
      rd_chk(`CLC_ADDR_RAMP_FREQ, {5'h02, i[2:0]}, 1'b1);
      check("analog", analog_out, {1'b0, 2'b01, i[2:0], 1'b1, 2'b00, 3'h5});
    end
    // Automatic scheme hides the step from the analog side
    clc_host_model_inst.wr(`CLC_ADDR_OFFSET, 8'hFF);
    rd_chk(`CLC_ADDR_OFFSET, 8'hE0, 1'b1);
    check("analog", analog_out, {1'b0, 2'b01, 3'h7, 1'b1, 2'b00, 3'h5});
    // Manual scheme applies each step
    for (i = 0; i < 4; i++) begin
      clc_host_model_inst.wr(`CLC_ADDR_OFFSET, {1'b0, i[1:0], 5'h1F});
      rd_chk(`CLC_ADDR_OFFSET, {1'b0, i[1:0], 5'h00}, 1'b1);
      check("analog", analog_out, {1'b0, 2'b01, 3'h7, 1'b0, i[1:0], 3'h5});
    end
    // Every lockout code
    for (i = 0; i < 8; i++) begin
      clc_host_model_inst.wr(`CLC_ADDR_LOCKOUT, {5'h1F, i[2:0]});
      rd_chk(`CLC_ADDR_LOCKOUT, {5'h00, i[2:0]}, 1'b1);
      check("analog", analog_out, {1'b0, 2'b01, 3'h7, 1'b0, 2'b11, i[2:0]});
    end
    // Unmapped write leaves no hit and the lockout register unchanged
    clc_host_model_inst.wr(8'hD5, 8'hFA);
    check("cmd_hit_wr", {11'h000, cmd_hit}, 12'h000);
    rd_chk(`CLC_ADDR_LOCKOUT, 8'h07, 1'b1);
    // Unmapped code reads zero without a hit
    rd_chk(8'hD5, 8'h00, 1'b0);
    // Second reset reloads other straps and drops host values
    do_reset(3'b010);
    rd_chk(`CLC_ADDR_RAMP_FREQ, 8'h23, 1'b1);
    rd_chk(`CLC_ADDR_OFFSET, 8'h80, 1'b1);
    rd_chk(`CLC_ADDR_LOCKOUT, 8'h05, 1'b1);
    print_verdict();
  end
endmodule : tb_top
